// file: core/safety_relay_pkg.sv
// constants for the safety relay sequencer: register map, fields, timing
package safety_relay_pkg;
  // register byte offsets on the avalon slave
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] DELAY_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] FAULT_OFS = 4'hC;
  // control register fields
  localparam int DUAL_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // start modes
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_MONITOR = 2'h2;
  // delay selector, in milliseconds
  localparam logic [15:0] DELAY_RST = 16'h03E8;
  // fault register bits
  localparam int WELD_BIT = 0;
  localparam int FBCK_BIT = 1;
  localparam int SHORT_BIT = 2;
  localparam int WDOG_BIT = 3;
  // sensed input vector positions
  localparam int IN_CH1 = 0;
  localparam int IN_CH2 = 1;
  localparam int IN_SHORT = 2;
  localparam int IN_START = 3;
  localparam int IN_ABORT = 4;
  localparam int IN_EARTH = 5;
  localparam int IN_CONT = 6;
  localparam int IN_W = 7;
  // timing: figures in their own unit
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int RECOVER_S = 60;
  localparam int RECOVER_MS = RECOVER_S * 1000;
  localparam int WD_EXTRA_MS = 50;
  localparam int WD_PCT = 15;
  localparam int MON_WAIT_MS = 100;
  localparam int CHECK_MS = 20;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACTIVE = 4'b0010,
    ST_DELAY = 4'b0100,
    ST_LOCK = 4'b1000
  } seq_state_t;
endpackage : safety_relay_pkg

// file: core/safety_relay_sequencer.sv
// emergency-stop safety relay sequencer with avalon-mm register slave
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - ready only with abort and start loops closed
// - activation closes all outputs, lights channel indicators
// - start indicator follows start loop until active
// - input open drops instantaneous outputs at once
// - delayed outputs open when delay expires
// - no restart before delay ends and ready
// - delay length comes from selector register
// - abort loop opening ends delay at once
// - single channel: one input, earth faults detected
// - dual channel: two inputs, shorts detected
// - automatic start needs closed input and start loop, the same as manual
// - manual start needs input and start loop
// - monitored start needs wait then start close
// - delayed outputs open by delay+50ms+15% always
// - power and channel indicators mirror their state
// - welded contact blocks reactivation
// - internal error may open delayed outputs early
// - earth fault drops all but the start indicator; recover after minute
// - relay feedback checked in idle and active only, from 20 ms after each state change, mismatch refuses
module safety_relay_sequencer
  import safety_relay_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = MS_NS / CLK_NS,
  parameter int unsigned RECOVER_TICKS = RECOVER_MS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic inChOne,
  input wire logic inChTwo,
  input wire logic shortSense,
  input wire logic startLoop,
  input wire logic delayAbortLoop,
  input wire logic earthFault,
  input wire logic contactsOpen,
  output logic instRelayOne,
  output logic instRelayTwo,
  output logic dlyRelayOne,
  output logic dlyRelayTwo,
  output logic powerIndicator,
  output logic startIndicator,
  output logic chanOneIndicator,
  output logic chanTwoIndicator,
  output logic chanOneDelayedIndicator,
  output logic chanTwoDelayedIndicator
);

  logic [IN_W-1:0] syncA_reg; // first stage, read only by second
  logic [IN_W-1:0] syncB_reg;
  logic [IN_W-1:0] syncC_reg;
  logic [IN_W-1:0] sense_reg; // debounced view of the pins
  logic [2:0] ctrl_reg; // mode and channel count
  logic [15:0] delay_reg; // selector in ms
  logic [3:0] fault_reg; // sticky fault flags
  logic [3:0] faultSet; // fault events this cycle
  seq_state_t state_reg;
  seq_state_t stateNext;
  logic [31:0] preCnt_reg; // millisecond prescaler
  logic msTick;
  logic [15:0] dlyCnt_reg; // delay remaining, ms
  logic [17:0] wdCnt_reg; // independent backstop, ms
  logic [17:0] wdLimit_reg;
  logic [15:0] monCnt_reg; // monitored start wait, ms
  logic [15:0] chkCnt_reg; // feedback check timer, ms
  logic [31:0] recCnt_reg; // earth fault recovery, ms
  logic startPrev_reg;
  logic inClosed, startOk, abortOk, earthOn, ready, canStart;
  logic monDone, chkDone, busAck;

  // pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    syncA_reg <= {contactsOpen, earthFault, delayAbortLoop, startLoop,
                  shortSense, inChTwo, inChOne};
    syncB_reg <= syncA_reg;
    syncC_reg <= syncB_reg;
    if (srst) begin
      sense_reg <= '0;
    end else begin
      for (int i = 0; i < IN_W; i++) begin
        if (syncB_reg[i] == syncC_reg[i]) begin
          sense_reg[i] <= syncC_reg[i];
        end
      end
    end
  end

  // single channel reads one contact; dual needs both closed
  assign inClosed = ctrl_reg[DUAL_BIT] ? (sense_reg[IN_CH1] & sense_reg[IN_CH2])
                                       : sense_reg[IN_CH1];
  assign startOk = sense_reg[IN_START];
  assign abortOk = sense_reg[IN_ABORT];
  assign earthOn = sense_reg[IN_EARTH];
  assign ready = abortOk & startOk;
  assign monDone = (monCnt_reg >= 16'(MON_WAIT_MS));
  assign chkDone = (chkCnt_reg >= 16'(CHECK_MS));

  // activation condition per start mode; any fault blocks it
  always_comb begin
    canStart = ready & inClosed & sense_reg[IN_CONT] & ~|fault_reg;
    case (ctrl_reg[MODE_LSB +: 2])
      MODE_AUTO: canStart = canStart;
      MODE_MANUAL: canStart = canStart;
      MODE_MONITOR: canStart = canStart & monDone & ~startPrev_reg;
      default: canStart = 1'b0;
    endcase
  end

  // millisecond tick keeps the long timers narrow, all but the 32-bit recovery count
  always_ff @(posedge clk) begin
    if (srst || preCnt_reg >= CYC_PER_MS - 1) begin
      preCnt_reg <= '0;
    end else begin
      preCnt_reg <= preCnt_reg + 32'h1;
    end
  end
  assign msTick = (preCnt_reg >= CYC_PER_MS - 1);

  // fault events; shorts only seen in dual channel wiring
  always_comb begin
    faultSet = '0;
    faultSet[WELD_BIT] = (state_reg == ST_IDLE) & chkDone & ~sense_reg[IN_CONT];
    faultSet[FBCK_BIT] = (state_reg == ST_ACTIVE) & chkDone & sense_reg[IN_CONT];
    faultSet[SHORT_BIT] = ctrl_reg[DUAL_BIT] & sense_reg[IN_SHORT];
    faultSet[WDOG_BIT] = (state_reg == ST_DELAY) & (wdCnt_reg >= wdLimit_reg);
  end

  // sequencer state
  always_comb begin
    stateNext = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (canStart) begin
          stateNext = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        // a fault or an opened input leaves the instantaneous set open
        if (!inClosed || faultSet[SHORT_BIT] || faultSet[FBCK_BIT]) begin
          stateNext = ST_DELAY;
        end
      end
      ST_DELAY: begin
        // restart only through idle, once the interval is over
        if (!abortOk) begin
          stateNext = ST_IDLE;
        end else if (dlyCnt_reg == 16'h0000 || |fault_reg) begin
          stateNext = ST_IDLE;
        end
      end
      ST_LOCK: begin
        if (!earthOn && recCnt_reg >= RECOVER_TICKS) begin
          stateNext = ST_IDLE;
        end
      end
      default: stateNext = ST_IDLE;
    endcase
    if (earthOn) begin
      stateNext = ST_LOCK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= stateNext;
    end
  end

  // delay interval, counted in ms ticks
  always_ff @(posedge clk) begin
    if (srst || !abortOk) begin
      dlyCnt_reg <= '0;
    end else if (state_reg == ST_ACTIVE && stateNext == ST_DELAY) begin
      dlyCnt_reg <= delay_reg;
    end else if (msTick && dlyCnt_reg != 16'h0000) begin
      dlyCnt_reg <= dlyCnt_reg - 16'h0001;
    end
  end

  // backstop: forced open no later than delay + 50 ms + 15 %
  always_ff @(posedge clk) begin
    if (srst) begin
      wdCnt_reg <= '0;
      wdLimit_reg <= '0;
    end else if (state_reg == ST_ACTIVE) begin
      wdCnt_reg <= '0;
      wdLimit_reg <= 18'({2'b00, delay_reg} + 18'(WD_EXTRA_MS)
                     + 18'((32'(delay_reg) * WD_PCT) / 100));
    end else if (state_reg == ST_DELAY && msTick) begin
      wdCnt_reg <= wdCnt_reg + 18'h00001;
    end
  end

  // monitored start: input closed and start loop open long enough
  always_ff @(posedge clk) begin
    if (srst || state_reg != ST_IDLE || !inClosed) begin
      monCnt_reg <= '0;
    end else if (startOk) begin
      monCnt_reg <= monCnt_reg; // hold; waiting only counts while open
    end else if (msTick && !monDone) begin
      monCnt_reg <= monCnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      startPrev_reg <= 1'b1; // a bridged start loop never counts as a fresh close
    end else begin
      startPrev_reg <= startOk;
    end
  end

  // feedback check window restarts on every state change
  always_ff @(posedge clk) begin
    if (srst || state_reg != stateNext) begin
      chkCnt_reg <= '0;
    end else if (msTick && !chkDone) begin
      chkCnt_reg <= chkCnt_reg + 16'h0001;
    end
  end

  // earth fault recovery counts only while the fault is absent
  always_ff @(posedge clk) begin
    if (srst || earthOn || state_reg != ST_LOCK) begin
      recCnt_reg <= '0;
    end else if (msTick && recCnt_reg < RECOVER_TICKS) begin
      recCnt_reg <= recCnt_reg + 32'h1;
    end
  end

  // outputs follow the next state so they move in step with it
  always_ff @(posedge clk) begin
    if (srst) begin
      instRelayOne <= 1'b0;
      instRelayTwo <= 1'b0;
      dlyRelayOne <= 1'b0;
      dlyRelayTwo <= 1'b0;
      chanOneIndicator <= 1'b0;
      chanTwoIndicator <= 1'b0;
      chanOneDelayedIndicator <= 1'b0;
      chanTwoDelayedIndicator <= 1'b0;
      startIndicator <= 1'b0;
      powerIndicator <= 1'b0;
    end else begin
      instRelayOne <= (stateNext == ST_ACTIVE);
      instRelayTwo <= (stateNext == ST_ACTIVE);
      dlyRelayOne <= (stateNext == ST_ACTIVE) || (stateNext == ST_DELAY);
      dlyRelayTwo <= (stateNext == ST_ACTIVE) || (stateNext == ST_DELAY);
      chanOneIndicator <= (stateNext == ST_ACTIVE);
      chanTwoIndicator <= (stateNext == ST_ACTIVE);
      chanOneDelayedIndicator <= (stateNext == ST_ACTIVE) || (stateNext == ST_DELAY);
      chanTwoDelayedIndicator <= (stateNext == ST_ACTIVE) || (stateNext == ST_DELAY);
      startIndicator <= startOk && (stateNext != ST_ACTIVE);
      powerIndicator <= (stateNext != ST_LOCK);
    end
  end

  // avalon slave: one wait cycle, then a one-cycle acknowledge
  assign busAck = (read || write) && waitrequest;
  always_ff @(posedge clk) begin
    if (srst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~busAck;
    end
  end

  // read data latched with the acknowledge; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (srst) begin
      readdata <= '0;
    end else if (busAck && read) begin
      if (address == CTRL_OFS) begin
        readdata <= {29'h0, ctrl_reg};
      end else if (address == DELAY_OFS) begin
        readdata <= {16'h0, delay_reg};
      end else if (address == STATUS_OFS) begin
        readdata <= {23'h0, state_reg, sense_reg[IN_CONT], earthOn, abortOk,
                     startOk, inClosed};
      end else if (address == FAULT_OFS) begin
        readdata <= {28'h0, fault_reg};
      end else begin
        readdata <= '0;
      end
    end
  end

  // control and selector writes land at the accepting edge
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= CTRL_RST;
      delay_reg <= DELAY_RST;
    end else if (write && !waitrequest) begin
      if (address == CTRL_OFS && byteenable[0]) begin
        ctrl_reg <= writedata[2:0];
      end else if (address == DELAY_OFS) begin
        if (byteenable[0]) begin
          delay_reg[7:0] <= writedata[7:0];
        end
        if (byteenable[1]) begin
          delay_reg[15:8] <= writedata[15:8];
        end
      end
    end
  end

  // sticky faults: write one to clear, a new event wins over the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_reg <= '0;
    end else if (write && !waitrequest && address == FAULT_OFS && byteenable[0]) begin
      fault_reg <= (fault_reg & ~writedata[3:0]) | faultSet;
    end else begin
      fault_reg <= fault_reg | faultSet;
    end
  end

  // checks
  instOff_a: assert property (@(posedge clk) disable iff (srst)
    (state_reg == ST_ACTIVE && !inClosed) |=> (!instRelayOne && !instRelayTwo))
    else $error("instantaneous outputs stayed closed after input opened");
  dlyHold_a: assert property (@(posedge clk) disable iff (srst)
    (state_reg == ST_DELAY && abortOk && dlyCnt_reg != 16'h0000 && fault_reg == 4'h0
     && !earthOn) |=> (dlyRelayOne && dlyRelayTwo))
    else $error("delayed outputs opened before delay ended");
  abortCut_a: assert property (@(posedge clk) disable iff (srst)
    (state_reg == ST_DELAY && !abortOk) |=> (!dlyRelayOne && dlyCnt_reg == 16'h0000))
    else $error("abort loop did not end delay");
  noRestart_a: assert property (@(posedge clk) disable iff (srst)
    (state_reg == ST_DELAY) |=> !instRelayOne)
    else $error("restart during delay interval");
  readyGate_a: assert property (@(posedge clk) disable iff (srst)
    $rose(instRelayOne) |-> $past(ready && inClosed && fault_reg == 4'h0))
    else $error("activation without ready condition");
  ledMatch_a: assert property (@(posedge clk) disable iff (srst)
    (chanOneIndicator == instRelayOne) && (chanTwoDelayedIndicator == dlyRelayTwo))
    else $error("channel indicator disagrees with outputs");
  startLed_a: assert property (@(posedge clk) disable iff (srst)
    instRelayOne |-> !startIndicator)
    else $error("start indicator lit while active");
  earthOff_a: assert property (@(posedge clk) disable iff (srst)
    earthOn |=> (!powerIndicator && !instRelayOne && !dlyRelayOne))
    else $error("earth fault left outputs closed");
  wdBound_a: assert property (@(posedge clk) disable iff (srst)
    (state_reg == ST_DELAY && wdCnt_reg >= wdLimit_reg) |=> ##1 !dlyRelayOne)
    else $error("delayed outputs exceeded backstop time");
  resetOff_a: assert property (@(posedge clk)
    srst |=> (!instRelayOne && !dlyRelayOne && !chanOneIndicator))
    else $error("outputs not open after reset");
  busPulse_a: assert property (@(posedge clk) disable iff (srst)
    !waitrequest |=> waitrequest)
    else $error("acknowledge longer than one cycle");
  activeCov_c: cover property (@(posedge clk) disable iff (srst) $rose(instRelayOne));
  expireCov_c: cover property (@(posedge clk) disable iff (srst)
    state_reg == ST_DELAY && dlyCnt_reg == 16'h0000 && abortOk);
  abortCov_c: cover property (@(posedge clk) disable iff (srst)
    state_reg == ST_DELAY && !abortOk);
  lockCov_c: cover property (@(posedge clk) disable iff (srst) state_reg == ST_LOCK);

endmodule : safety_relay_sequencer
`default_nettype wire

// file: testbench/field_switches.sv
// field side of the relay: e-stop, gate, start and abort switches plus contact feedback
`timescale 1ns/1ps
`default_nettype none
module field_switches (
  input wire logic [5:0] cmd,
  input wire logic [1:0] contactMode,
  input wire logic [3:0] relays,
  output logic inChOne,
  output logic inChTwo,
  output logic shortSense,
  output logic startLoop,
  output logic delayAbortLoop,
  output logic earthFault,
  output logic contactsOpen
);
  // switch levels follow the operator at once; bit order earth, short, abort, start, ch2, ch1
  assign {earthFault, shortSense, delayAbortLoop, startLoop, inChTwo, inChOne} = cmd;
  // guided contacts read open only with every coil off; 1 = welded, 2 = stuck open
  always_comb begin
    case (contactMode)
      2'h1: contactsOpen = 1'b0;
      2'h2: contactsOpen = 1'b1;
      default: contactsOpen = !((|relays) === 1'b1); // coils undriven count as open
    endcase
  end
endmodule : field_switches
`default_nettype wire

// file: testbench/safety_relay_sequencer_bench.sv
// self-checking bench for the safety relay sequencer
`timescale 1ns/1ps
`default_nettype none
module safety_relay_sequencer_bench;
  import safety_relay_pkg::*;
  localparam int MSC = 10; // cycles per ms tick, short for simulation
  localparam logic [9:0] ACT = 10'h3EF; // every contact closed, all lamps but start lit
  localparam logic [9:0] DLY = 10'h0E3; // only delayed contacts held
  localparam logic [9:0] IDL = 10'h020; // powered, contacts open
  localparam logic [9:0] NOST = 10'h3EF; // mask that skips the start lamp
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic [5:0] cmd = 6'h0C; // start and abort loops closed, input open
  logic [1:0] contactMode = 2'h0;
  logic inChOne, inChTwo, shortSense, startLoop, delayAbortLoop, earthFault, contactsOpen;
  logic instRelayOne, instRelayTwo, dlyRelayOne, dlyRelayTwo, powerIndicator, startIndicator;
  logic chanOneIndicator, chanTwoIndicator, chanOneDelayedIndicator, chanTwoDelayedIndicator;
  logic [9:0] outs; // all field outputs in one word
  int miscompares = 0;
  int samples_checked = 0;
  assign outs = {instRelayOne, instRelayTwo, dlyRelayOne, dlyRelayTwo, powerIndicator,
                 startIndicator, chanOneIndicator, chanTwoIndicator, chanOneDelayedIndicator,
                 chanTwoDelayedIndicator};
  // 100 MHz clock
  always #5 clk = ~clk;
  safety_relay_sequencer #(.CYC_PER_MS(MSC), .RECOVER_TICKS(5)) safety_relay_sequencer_i (
    .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .inChOne(inChOne), .inChTwo(inChTwo),
    .shortSense(shortSense), .startLoop(startLoop), .delayAbortLoop(delayAbortLoop),
    .earthFault(earthFault), .contactsOpen(contactsOpen), .instRelayOne(instRelayOne),
    .instRelayTwo(instRelayTwo), .dlyRelayOne(dlyRelayOne), .dlyRelayTwo(dlyRelayTwo),
    .powerIndicator(powerIndicator), .startIndicator(startIndicator),
    .chanOneIndicator(chanOneIndicator), .chanTwoIndicator(chanTwoIndicator),
    .chanOneDelayedIndicator(chanOneDelayedIndicator),
    .chanTwoDelayedIndicator(chanTwoDelayedIndicator));
  field_switches field_switches_i (.cmd(cmd), .contactMode(contactMode),
    .relays({instRelayOne, instRelayTwo, dlyRelayOne, dlyRelayTwo}), .inChOne(inChOne),
    .inChTwo(inChTwo), .shortSense(shortSense), .startLoop(startLoop),
    .delayAbortLoop(delayAbortLoop), .earthFault(earthFault), .contactsOpen(contactsOpen));
  // print the verdict and stop
  task automatic test_done();
    $display("compared %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  // count one comparison, report a difference
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // wait a bounded time for the masked outputs to settle to exp
  task automatic waitOuts(input string what, input int lim, input logic [9:0] exp,
                          input logic [9:0] m = 10'h3FF);
    int n;
    n = 0;
    while ((outs & m) !== exp && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(what, {22'h0, exp}, {22'h0, outs & m});
  endtask : waitOuts
  // masked outputs must keep exp for n cycles
  task automatic holdOuts(input string what, input int n, input logic [9:0] exp,
                          input logic [9:0] m = 10'h3FF);
    logic [9:0] seen;
    seen = exp;
    repeat (n) begin
      @(posedge clk);
      if ((outs & m) !== exp) seen = outs & m;
    end
    check(what, {22'h0, exp}, {22'h0, seen});
  endtask : holdOuts
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    // no local limit: only the watchdog ends a wait that never answers
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    check("bus wait edges", 32'h2, n);
  endtask : bus
  task automatic regWr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : regWr
  task automatic regChk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask : regChk
  // reset state and register defaults, unmapped place ignored
  task automatic runReset();
    holdOuts("reset outputs", 3, 10'h000, 10'h3CF);
    regChk("ctrl reset", CTRL_OFS, 32'h0);
    regChk("delay reset", DELAY_OFS, {16'h0, DELAY_RST});
    regChk("fault reset", FAULT_OFS, 32'h0);
    regChk("status idle", STATUS_OFS, {23'h0, ST_IDLE, 5'h16});
    regWr(4'hE, 32'hFFFFFFFF);
    regChk("unmapped read", 4'hE, 32'h0);
    regWr(DELAY_OFS, 32'h5); // five ms delay
    regChk("delay set", DELAY_OFS, 32'h5);
  endtask : runReset
  // automatic start, single channel, delay with refused early restart
  task automatic runAuto();
    waitOuts("start lamp idle", 12, 10'h030);
    cmd <= 6'h0D;
    waitOuts("auto on", 12, ACT);
    cmd <= 6'h0C; // operator opens the input
    waitOuts("inst open", 10, DLY, NOST);
    cmd <= 6'h0D;
    holdOuts("restart refused", 25, DLY, NOST);
    waitOuts("restart after delay", 80, ACT);
    cmd <= 6'h0C;
    waitOuts("inst open again", 10, DLY, NOST);
    holdOuts("delay holds", 3 * MSC, DLY, NOST);
    waitOuts("delay ends", 40, IDL, NOST);
  endtask : runAuto
  // abort loop ends the delay and blocks readiness
  task automatic runAbort();
    cmd <= 6'h0D;
    waitOuts("on before abort", 12, ACT);
    cmd <= 6'h0C;
    waitOuts("delay before abort", 10, DLY, NOST);
    cmd <= 6'h04;
    waitOuts("abort ends delay", 10, IDL, NOST);
    cmd <= 6'h05;
    holdOuts("abort open not ready", 30, IDL, NOST);
    cmd <= 6'h0D;
    waitOuts("abort closed ready", 12, ACT);
    cmd <= 6'h0C;
    waitOuts("off after abort", 90, IDL, NOST);
  endtask : runAbort
  // manual start needs input and start loop
  task automatic runManual();
    cmd <= 6'h08;
    regWr(CTRL_OFS, {29'h0, MODE_MANUAL, 1'b0});
    waitOuts("start lamp off", 12, IDL);
    cmd <= 6'h09;
    holdOuts("manual no start", 30, IDL);
    cmd <= 6'h0D;
    waitOuts("manual on", 12, ACT);
    cmd <= 6'h0C;
    waitOuts("manual off", 90, IDL, NOST);
    // start mode code three never activates
    regWr(CTRL_OFS, {29'h0, 2'h3, 1'b0});
    cmd <= 6'h0D;
    holdOuts("mode three idle", 30, IDL, NOST);
    cmd <= 6'h0C;
  endtask : runManual
  // monitored start needs start loop open for the wait period first
  task automatic runMonitor();
    regWr(CTRL_OFS, {29'h0, MODE_MONITOR, 1'b0});
    cmd <= 6'h0D;
    holdOuts("stale start", 30, IDL, NOST);
    cmd <= 6'h09;
    repeat (20 * MSC) @(posedge clk);
    cmd <= 6'h0D;
    holdOuts("early start", 30, IDL, NOST);
    cmd <= 6'h09;
    repeat ((MON_WAIT_MS + 10) * MSC) @(posedge clk);
    cmd <= 6'h0D;
    waitOuts("monitored on", 12, ACT);
    cmd <= 6'h0C;
    waitOuts("monitored off", 90, IDL, NOST);
  endtask : runMonitor
  // dual channel: both needed, ch1 opening opens, short ends delay early
  task automatic runDual();
    regWr(CTRL_OFS, 32'h1);
    cmd <= 6'h0D;
    holdOuts("one channel only", 30, IDL, NOST);
    cmd <= 6'h0F;
    waitOuts("dual on", 12, ACT);
    cmd <= 6'h0E;
    waitOuts("ch2 still closed", 10, DLY, NOST);
    cmd <= 6'h1C;
    waitOuts("short cuts delay", 10, IDL, NOST);
    regChk("short flag", FAULT_OFS, 32'h1 << SHORT_BIT);
    cmd <= 6'h0C;
    repeat (8) @(posedge clk); // the short must leave the synchroniser before the clear
    regWr(FAULT_OFS, 32'hF);
    regChk("short cleared", FAULT_OFS, 32'h0);
    regWr(CTRL_OFS, 32'h0);
    repeat (8 * MSC) @(posedge clk);
  endtask : runDual
  // welded and stuck contacts found by the feedback check
  task automatic runContacts();
    contactMode <= 2'h1;
    repeat (30 * MSC) @(posedge clk);
    contactMode <= 2'h0;
    cmd <= 6'h0D;
    holdOuts("weld blocks start", 30, IDL, NOST);
    regChk("weld flag", FAULT_OFS, 32'h1 << WELD_BIT);
    regWr(FAULT_OFS, 32'hF);
    waitOuts("on after clear", 12, ACT);
    contactMode <= 2'h2;
    waitOuts("stuck open found", 30 * MSC, 10'h000, 10'h300);
    regChk("feedback flag", FAULT_OFS, 32'h1 << FBCK_BIT);
    contactMode <= 2'h0;
    cmd <= 6'h0C;
    regWr(FAULT_OFS, 32'hF);
    repeat (8 * MSC) @(posedge clk);
  endtask : runContacts
  // earth fault drops everything but the start lamp until recovered
  task automatic runEarth();
    cmd <= 6'h0D;
    waitOuts("on before earth", 12, ACT);
    cmd <= 6'h2D;
    waitOuts("earth drops all", 10, 10'h000, NOST);
    cmd <= 6'h0D;
    holdOuts("recovery time", 3 * MSC, 10'h000, NOST);
    waitOuts("back after recovery", 100, ACT);
  endtask : runEarth
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    runReset();
    runAuto();
    runAbort();
    runManual();
    runMonitor();
    runDual();
    runContacts();
    runEarth();
    test_done();
  end
  // watchdog well beyond the expected run of a few thousand cycles
  initial begin
    repeat (10000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule : safety_relay_sequencer_bench
`default_nettype wire
